// ==== hdl/adsq_pkg.sv ====
// shared constants for the converter sequencer and daisy-chain port
package adsq_pkg;
  // ----------------------------------------------------------------
  // serial command framing
  // ----------------------------------------------------------------
  localparam int          CMD_W     = 16;        // one command word per converter
  localparam int          BCNT_W    = 5;         // frame bit counter width
  localparam logic [4:0]  BCNT_FULL = 5'h10;     // counter value of a whole word
  localparam logic [15:0] TX_RST    = 16'h0000;  // output word after reset
  // ----------------------------------------------------------------
  // conversion data and buffering
  // ----------------------------------------------------------------
  localparam int          NCH_DEF   = 8;         // input channels of the variant
  localparam int          CH_W      = 4;         // channel tag width
  localparam int          RES_W     = 12;        // conversion result width
  localparam int          FIFO_DEP  = 16;        // result buffer depth
  // ----------------------------------------------------------------
  // system-side frame tracking
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADSQ_FR_IDLE = 2'b00,  // chip select high, output word may change
    ADSQ_FR_BUSY = 2'b01,  // chip select low, output word frozen
    ADSQ_FR_DONE = 2'b10   // chip select just rose, take the command
  } adsq_frame_t;
endpackage

// ==== hdl/adsq_top.sv ====
// converter channel sequencer, daisy-chain serial port and result buffer
//
// Functional notes
// - empty enable register converts channel zero only
// - sequence starts at lowest enabled channel
// - ascending enabled channels, wrap, repeat forever
// - new enables take effect one conversion later
// - enable write restarts at lowest new channel
// - beyond sixteen bits, forward received bits out
// - execute only last word before select rises
// - next output from command reply or conversion
// - conversion starts on start pin falling edge
// - sixteen-bit output word, one bit per clock
`timescale 1ns/1ps

// ------------------------------------------------------------------
// result buffer
// ------------------------------------------------------------------
module adsq_fifo #(
  parameter int W   = 16,
  parameter int DEP = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEP);
  logic [W-1:0]  mem [DEP];   // storage words
  logic [AW-1:0] wr_ptr_r;    // next slot to write
  logic [AW-1:0] rd_ptr_r;    // oldest word
  logic [AW:0]   cnt_r;       // words held
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r];

  // occupancy after this edge
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // storage has no reset, only pointers, count and flags do
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers wrap; depth is a power of two
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
    end
  end

  // flags registered from next count so they stay honest
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      in_ready  <= (cnt_nxt != (AW+1)'(DEP));
      out_valid <= (cnt_nxt != '0);
    end
  end
endmodule

// ------------------------------------------------------------------
// top level
// ------------------------------------------------------------------
module adsq_top import adsq_pkg::*; #(
  parameter int NCH = NCH_DEF
) (
  // system clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // serial link pins
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             sdi,
  output logic                  sdo_o,
  output logic                  sdo_oe,
  // conversion start pin
  input  wire logic             convert_start_n,
  // analog core request and result
  output logic                  conv_req,
  output logic [CH_W-1:0]       conv_ch,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] conv_data,
  output logic                  conv_ready,
  // channel enable write
  input  wire logic             chan_wr,
  input  wire logic [NCH-1:0]   chan_wdata,
  output logic [NCH-1:0]        chan_en,
  // executed command and its reply
  output logic                  cmd_strobe,
  output logic [CMD_W-1:0]      cmd_data,
  input  wire logic             reply_valid,
  input  wire logic [CMD_W-1:0] reply_data
);
  // ----------------------------------------------------------------
  // link domain (sclk)
  // ----------------------------------------------------------------
  logic [CMD_W-1:0]  lk_rx_r;     // last sixteen received bits
  logic [BCNT_W-1:0] lk_bcnt_r;   // bits received, saturating
  logic              lk_new_r;    // next rising edge opens a frame
  logic [BCNT_W-1:0] lk_ocnt_r;   // bits sent this frame
  logic [CMD_W-1:0]  tx_word_r;   // word to shift out, system domain

  // frame opening flag, set while select is high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      lk_new_r <= 1'b1;
    end else begin
      lk_new_r <= 1'b0;
    end
  end

  // input shift; kept after select rises so the command can be read
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      lk_rx_r   <= '0;
      lk_bcnt_r <= '0;
    end else begin
      lk_rx_r <= {lk_rx_r[CMD_W-2:0], sdi};
      if (lk_new_r) begin
        lk_bcnt_r <= BCNT_W'(1);
      end else if (lk_bcnt_r != BCNT_FULL) begin
        lk_bcnt_r <= lk_bcnt_r + 1'b1;
      end
    end
  end

  // output on falling edges; master samples on rising edges
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdo_o     <= 1'b0;
      sdo_oe    <= 1'b0;
      lk_ocnt_r <= '0;
    end else begin
      sdo_oe <= 1'b1;
      if (lk_ocnt_r != BCNT_FULL) begin
        sdo_o     <= tx_word_r[CMD_W-1-lk_ocnt_r[3:0]];
        lk_ocnt_r <= lk_ocnt_r + 1'b1;
      end else begin
        sdo_o <= lk_rx_r[CMD_W-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cs_m_r;     // first stage, read by second only
  logic cs_s_r;     // chip select in system domain
  logic cst_m_r;    // first stage, read by second only
  logic cst_s_r;    // start pin in system domain
  logic cst_d_r;    // previous start level for edge detect

  // two flops per pin plus a start edge flop, all reset to the idle high level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_m_r  <= 1'b1;
      cs_s_r  <= 1'b1;
      cst_m_r <= 1'b1;
      cst_s_r <= 1'b1;
      cst_d_r <= 1'b1;
    end else begin
      cs_m_r  <= cs_n;
      cs_s_r  <= cs_m_r;
      cst_m_r <= convert_start_n;
      cst_s_r <= cst_m_r;
      cst_d_r <= cst_s_r;
    end
  end

  // ----------------------------------------------------------------
  // channel sequencer
  // ----------------------------------------------------------------
  logic             conv_go;      // start pin fell
  logic [CH_W-1:0]  seq_ch_r;     // channel for the next conversion
  logic             restart_r;    // new enables waiting to take over

  // bit n enables channel n; empty mask yields channel 0
  function automatic logic [CH_W-1:0] seq_first(input logic [NCH-1:0] en);
    logic [CH_W-1:0] res;
    res = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (en[i]) begin
        res = CH_W'(i);
      end
    end
    return res;
  endfunction

  // lowest enabled channel above cur, else wrap to the first
  function automatic logic [CH_W-1:0] seq_next(input logic [CH_W-1:0] cur,
                                               input logic [NCH-1:0]  en);
    logic [CH_W-1:0] res;
    res = seq_first(en);
    for (int i = NCH - 1; i >= 0; i--) begin
      if (en[i] && (CH_W'(i) > cur)) begin
        res = CH_W'(i);
      end
    end
    return res;
  endfunction

  assign conv_go = cst_d_r && !cst_s_r;

  // enable register, written from the user side
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan_en <= '0;
    end else if (chan_wr) begin
      chan_en <= chan_wdata;
    end
  end

  // restart flag; a write in the same cycle as a start wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      restart_r <= 1'b0;
    end else if (chan_wr) begin
      restart_r <= 1'b1;
    end else if (conv_go) begin
      restart_r <= 1'b0;
    end
  end

  // channel pointer steps once per conversion start
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seq_ch_r <= '0;
    end else if (conv_go) begin
      if (chan_wr) begin
        seq_ch_r <= seq_first(chan_wdata);
      end else if (restart_r) begin
        seq_ch_r <= seq_first(chan_en);
      end else begin
        seq_ch_r <= seq_next(seq_ch_r, chan_en);
      end
    end
  end

  // conversion request pulse with the already selected channel
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_req <= 1'b0;
      conv_ch  <= '0;
    end else begin
      conv_req <= conv_go;
      if (conv_go) begin
        conv_ch <= seq_ch_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // result buffer; full buffer stalls the analog core via conv_ready
  // ----------------------------------------------------------------
  logic             res_valid;    // buffered result available
  logic [CMD_W-1:0] res_data;     // channel tag and result
  logic             res_pop;      // take head into the output word

  adsq_fifo #(
    .W   (CMD_W),
    .DEP (FIFO_DEP)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (conv_done),
    .in_data   ({conv_ch, conv_data}),
    .in_ready  (conv_ready),
    .out_valid (res_valid),
    .out_data  (res_data),
    .out_ready (res_pop)
  );

  // ----------------------------------------------------------------
  // frame tracking and output word selection
  // ----------------------------------------------------------------
  adsq_frame_t      fr_r;         // frame state
  logic             fresh_r;      // output word not yet sent
  logic             rep_pend_r;   // reply waiting for a free slot
  logic [CMD_W-1:0] rep_r;        // held reply word

  // frame state follows synchronised chip select
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fr_r <= ADSQ_FR_IDLE;
    end else begin
      case (fr_r)
        ADSQ_FR_IDLE: begin
          if (!cs_s_r) begin
            fr_r <= ADSQ_FR_BUSY;
          end
        end
        ADSQ_FR_BUSY: begin
          if (cs_s_r) begin
            fr_r <= ADSQ_FR_DONE;
          end
        end
        ADSQ_FR_DONE: begin
          fr_r <= ADSQ_FR_IDLE;
        end
        default: begin
          fr_r <= ADSQ_FR_IDLE;
        end
      endcase
    end
  end

  // link words are static while select is high, so read them here
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_strobe <= 1'b0;
      cmd_data   <= '0;
    end else begin
      // only the last word is executed
      cmd_strobe <= (fr_r == ADSQ_FR_DONE) && (lk_bcnt_r == BCNT_FULL);
      if ((fr_r == ADSQ_FR_DONE) && (lk_bcnt_r == BCNT_FULL)) begin
        cmd_data <= lk_rx_r;
      end
    end
  end

  // reply holder; a new reply wins over the slot being taken
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rep_pend_r <= 1'b0;
      rep_r      <= '0;
    end else if (reply_valid) begin
      rep_pend_r <= 1'b1;
      rep_r      <= reply_data;
    end else if ((fr_r == ADSQ_FR_IDLE) && cs_s_r) begin
      rep_pend_r <= 1'b0;
    end
  end

  assign res_pop = (fr_r == ADSQ_FR_IDLE) && cs_s_r && !rep_pend_r
                   && !reply_valid && !fresh_r && res_valid;

  // output word changes only between frames
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_word_r <= TX_RST;
      fresh_r   <= 1'b0;
    end else if (fr_r == ADSQ_FR_DONE) begin
      fresh_r <= 1'b0;
    end else if ((fr_r == ADSQ_FR_IDLE) && cs_s_r) begin
      if (rep_pend_r && !reply_valid) begin
        tx_word_r <= rep_r;
        fresh_r   <= 1'b1;
      end else if (res_pop) begin
        tx_word_r <= res_data;
        fresh_r   <= 1'b1;
      end
    end
  end
endmodule

// ==== testbench/adsq_top_sva.sv ====
// concurrent checks on the sequencer and serial port
`timescale 1ns/1ps
module adsq_top_sva import adsq_pkg::*; #(
  parameter int NCH = NCH_DEF
) (
  // clock and reset
  input wire logic             clk_sys,
  input wire logic             rst,
  // serial pins
  input wire logic             cs_n,
  input wire logic             sdo_o,
  input wire logic             sdo_oe,
  // conversions
  input wire logic             convert_start_n,
  input wire logic             conv_req,
  input wire logic [CH_W-1:0]  conv_ch,
  // channel enables
  input wire logic             chan_wr,
  input wire logic [NCH-1:0]   chan_wdata,
  input wire logic [NCH-1:0]   chan_en,
  // executed command
  input wire logic             cmd_strobe,
  input wire logic [CMD_W-1:0] cmd_data
);
  // ---------
  // helpers
  // ---------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [1:0]     nreq_r;  // starts since the last mask write
  logic [NCH-1:0] below;   // enabled channels under conv_ch
  assign below = chan_en & ((NCH'(1) << conv_ch) - NCH'(1));
  // the first start after a write still uses the old channel, so skip it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nreq_r <= 2'h2;
    end else if (chan_wr) begin
      nreq_r <= 2'h0;
    end else if (conv_req && nreq_r != 2'h2) begin
      nreq_r <= nreq_r + 2'h1;
    end
  end
  // ---------
  // checks
  // ---------
  AST_REQ_LAT: assert property ($fell(convert_start_n) |-> ##[2:5] conv_req)
    else $error("no request after start pin fell");
  AST_REQ_ONE: assert property (conv_req |=> !conv_req)
    else $error("request longer than one cycle");
  AST_CH_HOLD: assert property ($changed(conv_ch) |-> conv_req)
    else $error("channel changed without a request");
  AST_CH_ZERO: assert property (conv_req && nreq_r != 2'h0 && chan_en == '0
    |-> conv_ch == '0)
    else $error("empty mask converted a nonzero channel");
  AST_CH_FIRST: assert property (conv_req && nreq_r == 2'h1 && chan_en != '0
    |-> chan_en[conv_ch] && below == '0)
    else $error("restart did not pick the lowest enabled channel");
  AST_CH_EN: assert property (conv_req && nreq_r != 2'h0 && chan_en != '0
    |-> chan_en[conv_ch])
    else $error("converted a disabled channel");
  AST_EN_WR: assert property (chan_wr |=> chan_en == $past(chan_wdata))
    else $error("enable mask not written");
  AST_SDO_IDLE: assert property (cs_n && $past(cs_n) |-> !sdo_oe && !sdo_o)
    else $error("serial output driven while deselected");
  AST_CMD_HOLD: assert property ($changed(cmd_data) |-> cmd_strobe)
    else $error("command changed without a strobe");
  AST_STROBE_CS: assert property (cmd_strobe |-> cs_n && $past(cs_n, 2))
    else $error("command executed before select rose");
endmodule

bind adsq_top adsq_top_sva #(.NCH(NCH)) u_sva (
  .clk_sys, .rst, .cs_n, .sdo_o, .sdo_oe, .convert_start_n, .conv_req, .conv_ch,
  .chan_wr, .chan_wdata, .chan_en, .cmd_strobe, .cmd_data);

// ==== testbench/adsq_spi_master.sv ====
// serial master model at the far end of the converter chain
`timescale 1ns/1ps
module adsq_spi_master (
  // link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // --------------
  // frame engine
  // --------------
  localparam time HALF = 32;  // half of the 64 ns link period
  // clock idles high and stands still between frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #HALF;
      sclk = 1'b1;
      rx = {rx[30:0], miso};
      #HALF;
    end
    cs_n = 1'b1;
    // released line flips so a stale level is never mistaken for data
    mosi = ~mosi;
  endtask
endmodule

// ==== testbench/tb_adsq_top.sv ====
// self-checking bench for the converter sequencer and serial port
`timescale 1ns/1ps
module tb_adsq_top import adsq_pkg::*; ();
  // ---------
  // signals
  // ---------
  logic             clk_sys = 1'b0;         // system clock
  logic             rst = 1'b1;             // reset, active high
  logic             sclk, cs_n, sdi, miso;  // link pins
  logic             sdo_o, sdo_oe;          // device output and enable
  logic             convert_start_n = 1'b1; // start pin, idle high
  logic             conv_req, conv_ready;
  logic [CH_W-1:0]  conv_ch;
  logic             conv_done = 1'b0;
  logic [RES_W-1:0] conv_data = '0;
  logic             chan_wr = 1'b0;
  logic [7:0]       chan_wdata = '0, chan_en;
  logic             cmd_strobe, reply_valid = 1'b0;
  logic [CMD_W-1:0] cmd_data, reply_data = '0;
  int               fail_count = 0;         // mismatches seen
  int               cmp_count = 0;          // comparisons made
  // released output shows the inverse level, never a stale one
  assign miso = sdo_oe ? sdo_o : ~sdo_o;
  always #25 clk_sys = ~clk_sys;
  adsq_top #(.NCH(8)) uut (.clk_sys, .rst, .sclk, .cs_n, .sdi, .sdo_o, .sdo_oe,
    .convert_start_n, .conv_req, .conv_ch, .conv_done, .conv_data, .conv_ready,
    .chan_wr, .chan_wdata, .chan_en, .cmd_strobe, .cmd_data, .reply_valid, .reply_data);
  adsq_spi_master u_master (.sclk, .cs_n, .mosi(sdi), .miso);
  // ---------
  // helpers
  // ---------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // start pin low for two cycles, returns the requested channel
  task automatic conv(output logic [3:0] ch);
    ch = 4'hF;
    @(posedge clk_sys);
    convert_start_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    convert_start_n <= 1'b1;
    for (int i = 0; i < 6 && ch === 4'hF; i++) begin
      @(posedge clk_sys);
      #1;
      if (conv_req === 1'b1) ch = conv_ch;
    end
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic wr_mask(input logic [7:0] m);
    @(posedge clk_sys);
    chan_wr    <= 1'b1;
    chan_wdata <= m;
    @(posedge clk_sys);
    chan_wr    <= 1'b0;
  endtask
  // two-word frame: own word first, then our first word passed through
  task automatic frame(input logic [31:0] tx, input logic [15:0] own);
    logic [31:0] rx;
    bit          seen;
    seen = 1'b0;
    u_master.xfer(32, tx, rx);
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge clk_sys);
      #1;
      seen = (cmd_strobe === 1'b1);
    end
    check(16'(seen), 16'h1);
    check(rx[31:16], own);
    check(rx[15:0], tx[31:16]);
    check(cmd_data, tx[15:0]);
    repeat (4) @(posedge clk_sys);
  endtask
  // -----------
  // scenarios
  // -----------
  task automatic t_seq();
    logic [3:0] ch;
    int         exp_ch [11] = '{0, 0, 0, 2, 3, 5, 2, 3, 4, 7, 4};
    for (int i = 0; i < 11; i++) begin
      if (i == 2) wr_mask(8'h2C);
      if (i == 7) wr_mask(8'h90);
      conv(ch);
      check(16'(ch), 16'(exp_ch[i]));
    end
    $display("sequencer test done");
  endtask
  task automatic t_link();
    frame(32'h8001_7FFE, TX_RST);
    @(posedge clk_sys);
    reply_valid <= 1'b1;
    reply_data  <= 16'hC35A;
    @(posedge clk_sys);
    reply_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    frame(32'h5A5A_0001, 16'hC35A);
    $display("link test done");
  endtask
  // a frame shorter than one word must execute nothing
  task automatic t_short();
    logic [31:0] rx;
    bit          seen;
    seen = 1'b0;
    u_master.xfer(8, 32'h0000_00A5, rx);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1;
      seen = seen || (cmd_strobe === 1'b1);
    end
    check(16'(seen), 16'h0);
    check(cmd_data, 16'h0001);
    check(rx[15:0], 16'h00C3);
    $display("short frame test done");
  endtask
  // fill the buffer with no frames, then drain it word by word
  task automatic t_fill();
    int n = 0;
    @(posedge clk_sys);
    conv_done <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys);
      if (conv_ready === 1'b1) begin
        n++;
        conv_data <= 12'(n);
      end
    end
    conv_done <= 1'b0;
    #1;
    check(16'(conv_ready), 16'h0);
    check(16'(n), 16'(FIFO_DEP + 1));
    for (int i = 0; i < n; i++) begin
      frame({16'(i), 16'hA000 + 16'(i)}, {4'h4, 12'(i)});
    end
    frame(32'h0F0F_F0F0, {4'h4, 12'(n - 1)});
    check(16'(conv_ready), 16'h1);
    $display("buffer test done");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_seq();
    t_link();
    t_short();
    t_fill();
    summarize();
  end
  // watchdog at several times the expected run length
  initial begin
    #400_000;
    fail_count++;
    summarize();
  end
endmodule
